// *** hw/tpm_payload_mapper.sv ***
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - mode is chosen before the session starts and held for the whole session.
// - clear channel fills each sub-block with k_s contiguous user bits.
// - clear channel keeps user bit order inside sub-blocks.
// - two-pair clear: first k_s bits to pair 1, next k_s to pair 2.
// - byte mode: n byte slots, LSB first, from bit one, n from 3 below 36.
// - two-pair byte: odd input bytes on pair 1, even bytes on pair 2.
// - two-pair byte accepts only even slot counts.
// - unaligned DS1: one single-bit slot plus 24 byte slots, no alignment.
// - unaligned DS1 framing is locked to the line, same position each sub-block.
// - unaligned DS1 bits go out in arrival order.
// - unaligned DS1 is refused on two pairs.
// - aligned DS1: framing bit first, slots 1..n, n 24 or 3 below 24.
// - aligned DS1 framing is expected at the first sub-block bit; a marker elsewhere only sets the align flag.
// - two-pair aligned DS1: 12 or 3 below 12 slots per pair, even slot counts.
// - two-pair aligned DS1: framing bit first on both pairs.
// - two-pair aligned DS1: odd slots on pair 1, even slots on pair 2.
// - unstructured 2.048 Mbit/s streams use the clear channel mapping.
// - unaligned structured 2.048: 32 byte slots, no single-bit slot.
// - unaligned structured 2.048 framing keeps one position every sub-block.
// - unaligned structured 2.048 bits go out in arrival order.
// - unaligned structured 2.048 is refused on two pairs.
module tpm_payload_mapper
    import tpm_pkg::*;
#(
    parameter int N_MAX = 36
) (
    input  wire  logic              REF_CLK,
    input  wire  logic              RSTN,
    input  wire  logic              PSEL,
    input  wire  logic              PENABLE,
    input  wire  logic              PWRITE,
    input  wire  logic [ADDR_W-1:0] PADDR,
    input  wire  logic [31:0]       PWDATA,
    output logic       [31:0]       PRDATA,
    output logic                    PREADY,
    output logic                    PSLVERR,
    input  wire  logic              USR_BIT,
    input  wire  logic              USR_FRM,
    input  wire  logic              USR_VALID,
    output logic                    USR_READY,
    output logic                    LN_BIT_P1,
    output logic                    LN_BIT_P2,
    output logic                    LN_VALID,
    output logic                    LN_SOB,
    output logic                    LN_TWO_PAIR,
    input  wire  logic              LN_READY
);

    localparam int KS_MAX = 1 + 8 * N_MAX;

    typedef struct packed {
        tpm_st_e           st;
        logic [2:0]        mode;
        logic              two;
        logic [5:0]        n;
        logic              i;
        logic [9:0]        cnt;
        logic [8:0]        ecnt;
        logic [KS_MAX-1:0] b0;
        logic [KS_MAX-1:0] b1;
        logic              cfg_err;
        logic              aln_err;
        logic [15:0]       sbc;
        logic [31:0]       rd;
    } tpm_s;

    tpm_s q;
    tpm_s d;

    // ========================================
    // functions
    function automatic logic tpm_cfg_ok(input logic [2:0] m, input logic two,
                                        input logic [5:0] n, input logic i);
        logic ok;
        ok = 1'b0;
        unique case (m)
            MODE_CLEAR, MODE_E1U: ok = (n >= N_MIN) && (n <= 6'(N_MAX));
            MODE_BYTE: ok = !i && (n >= N_MIN) && (n < N_BYTE_LIM)
                            && !(two && n[0]);
            MODE_DS1U: ok = i && (n == N_DS1) && !two;
            MODE_DS1A: ok = i && (n >= N_MIN)
                            && (two ? (n <= N_DS1_TWO) && !n[0]
                                    : (n <= N_DS1));
            MODE_E1S: ok = !i && (n == N_E1S) && !two;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // returns {pair, bit index} for the c-th bit of a sub-block period
    function automatic logic [9:0] tpm_map(input logic [2:0] m, input logic two,
                                           input logic [8:0] ks, input logic [9:0] c);
        logic [9:0] dd;
        logic [9:0] ee;
        logic [9:0] r;
        dd = c - 10'h001;
        ee = c - {1'b0, ks};
        r  = {1'b0, c[8:0]};
        if (two) begin
            if (m == MODE_BYTE) begin
                r = {c[3], c[9:4], c[2:0]};
            end else if (m == MODE_DS1A) begin
                if (c == 10'h000) begin
                    r = 10'h000;
                end else begin
                    r = {dd[3], {dd[9:4], dd[2:0]} + 9'h001};
                end
            end else if (c >= {1'b0, ks}) begin
                r = {1'b1, ee[8:0]};
            end
        end
        return r;
    endfunction

    // ========================================
    // derived sizes, fixed while a session runs, and the map position of the current bit
    logic [8:0] ks;
    logic [9:0] tot;
    logic [9:0] pos;
    logic       ds1a;

    assign ds1a = (q.mode == MODE_DS1A);
    assign ks   = {q.n, 3'h0} + {8'h00, q.i};
    assign tot  = q.two ? ({ks, 1'b0} - {9'h000, ds1a}) : {1'b0, ks};
    assign pos  = tpm_map(q.mode, q.two, ks, q.cnt);

    // ========================================
    // apb decode
    logic        wr;
    logic        rd_setup;
    logic        hit;
    logic [31:0] rmux;
    logic [2:0]  w_mode;
    logic [5:0]  w_n;

    assign wr       = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign hit      = (PADDR == OFS_CTRL) || (PADDR == OFS_STATUS) || (PADDR == OFS_SBCNT);
    assign w_mode   = PWDATA[CTRL_MODE_LO +: 3];
    assign w_n      = PWDATA[CTRL_N_LO +: 6];

    always_comb begin
        rmux = 32'h0000_0000;
        if (PADDR == OFS_CTRL) begin
            rmux[CTRL_START]       = (q.st != ST_IDLE);
            rmux[CTRL_MODE_LO +: 3] = q.mode;
            rmux[CTRL_TWO]         = q.two;
            rmux[CTRL_N_LO +: 6]   = q.n;
            rmux[CTRL_I]           = q.i;
        end else if (PADDR == OFS_STATUS) begin
            rmux[STAT_ACT]     = (q.st != ST_IDLE);
            rmux[STAT_CFG_ERR] = q.cfg_err;
            rmux[STAT_ALN_ERR] = q.aln_err;
        end else if (PADDR == OFS_SBCNT) begin
            rmux[15:0] = q.sbc;
        end
    end

    // ========================================
    // next state
    always_comb begin
        d = q;
        if (rd_setup) begin
            d.rd = rmux;
        end
        // error flags clear by writing one; later sets in this process win
        if (wr && PADDR == OFS_STATUS) begin
            if (PWDATA[STAT_CFG_ERR]) begin
                d.cfg_err = 1'b0;
            end
            if (PWDATA[STAT_ALN_ERR]) begin
                d.aln_err = 1'b0;
            end
        end
        unique case (q.st)
            ST_IDLE: begin
            end
            ST_FILL: begin
                if (USR_VALID) begin
                    if (pos[9]) begin
                        d.b1[pos[8:0]] = USR_BIT;
                    end else begin
                        d.b0[pos[8:0]] = USR_BIT;
                    end
                    if (q.two && ds1a && q.cnt == 10'h000) begin
                        d.b1[0] = USR_BIT;
                    end
                    // framing marker must sit on the first bit only
                    if (ds1a && (USR_FRM != (q.cnt == 10'h000))) begin
                        d.aln_err = 1'b1;
                    end
                    if (q.cnt == tot - 10'h001) begin
                        // period never restarts mid-session, so frames keep their place
                        d.cnt  = 10'h000;
                        d.ecnt = 9'h000;
                        d.st   = ST_EMIT;
                    end else begin
                        d.cnt = q.cnt + 10'h001;
                    end
                end
            end
            ST_EMIT: begin
                if (LN_READY) begin
                    d.b0 = q.b0 >> 1;
                    d.b1 = q.b1 >> 1;
                    if (q.ecnt == ks - 9'h001) begin
                        d.st  = ST_FILL;
                        d.sbc = q.sbc + 16'h0001;
                    end else begin
                        d.ecnt = q.ecnt + 9'h001;
                    end
                end
            end
        endcase
        // config writes land only while idle; a session ends on start cleared
        if (wr && PADDR == OFS_CTRL) begin
            if (q.st == ST_IDLE) begin
                d.mode = w_mode;
                d.two  = PWDATA[CTRL_TWO];
                d.n    = w_n;
                d.i    = PWDATA[CTRL_I];
                if (PWDATA[CTRL_START]) begin
                    if (tpm_cfg_ok(w_mode, PWDATA[CTRL_TWO], w_n, PWDATA[CTRL_I])) begin
                        d.st  = ST_FILL;
                        d.cnt = 10'h000;
                    end else begin
                        d.cfg_err = 1'b1;
                    end
                end
            end else if (!PWDATA[CTRL_START]) begin
                d.st = ST_IDLE;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            q         <= '0;
            q.st      <= ST_IDLE;
            q.mode    <= RST_MODE;
            q.n       <= RST_N;
        end else begin
            q <= d;
        end
    end

    // ========================================
    // outputs
    assign PRDATA      = q.rd;
    assign PREADY      = 1'b1;
    assign PSLVERR     = PSEL && PENABLE && !hit;
    assign USR_READY   = (q.st == ST_FILL);
    assign LN_VALID    = (q.st == ST_EMIT);
    assign LN_SOB      = (q.st == ST_EMIT) && (q.ecnt == 9'h000);
    assign LN_BIT_P1   = q.b0[0];
    assign LN_BIT_P2   = q.b1[0] & q.two;
    assign LN_TWO_PAIR = q.two;

    // ========================================
    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    logic act;
    logic take;
    logic ctrl_wr;
    logic go_wr;
    logic cfg_good;
    assign act      = (q.st != ST_IDLE);
    assign take     = (q.st == ST_FILL) && USR_VALID;
    assign ctrl_wr  = wr && (PADDR == OFS_CTRL);
    assign go_wr    = ctrl_wr && (q.st == ST_IDLE) && PWDATA[CTRL_START];
    assign cfg_good = tpm_cfg_ok(w_mode, PWDATA[CTRL_TWO], w_n, PWDATA[CTRL_I]);

    sequence s_last_fill;
        take && q.cnt == tot - 10'h001;
    endsequence
    sequence s_emit_start;
        q.st == ST_EMIT && q.ecnt == 9'h000;
    endsequence
    sequence s_last_emit;
        q.st == ST_EMIT && LN_READY && q.ecnt == ks - 9'h001;
    endsequence

    fill_to_emit_a: assert property (
        s_last_fill |=> s_emit_start)
        else $error("sub-block did not start emitting after last bit");

    emit_to_fill_a: assert property (
        s_last_emit |=> q.st == ST_FILL && q.sbc == $past(q.sbc) + 16'h0001)
        else $error("sub-block did not end after k_s bits");

    cfg_hold_a: assert property (
        act && $past(act) |-> $stable({q.mode, q.two, q.n, q.i}))
        else $error("configuration changed during session");

    no_two_unal_a: assert property (
        act |-> !(q.two && (q.mode == MODE_DS1U || q.mode == MODE_E1S)))
        else $error("unaligned mode running on two pairs");

    even_slots_a: assert property (
        act && q.two && (q.mode == MODE_BYTE || ds1a) |-> !q.n[0])
        else $error("odd slot count on two pairs");

    byte_range_a: assert property (
        act && q.mode == MODE_BYTE |-> !q.i && q.n >= N_MIN && q.n < N_BYTE_LIM)
        else $error("byte mode slot count out of range");

    ds1_shape_a: assert property (
        act && q.mode == MODE_DS1U |-> q.i && q.n == N_DS1 && ks == 9'h0c1)
        else $error("unaligned DS1 sub-block size wrong");

    e1_shape_a: assert property (
        act && q.mode == MODE_E1S |-> !q.i && ks == 9'h100)
        else $error("structured 2.048 sub-block size wrong");

    ds1a_range_a: assert property (
        act && ds1a |-> q.i && q.n <= (q.two ? N_DS1_TWO : N_DS1))
        else $error("aligned DS1 slot count out of range");

    one_pair_order_a: assert property (
        take && !q.two |=> q.b0[$past(q.cnt[8:0])] == $past(USR_BIT))
        else $error("bit not stored at its arrival position");

    frm_both_a: assert property (
        take && q.two && ds1a && q.cnt == 10'h000
        |=> q.b0[0] == $past(USR_BIT) && q.b1[0] == $past(USR_BIT))
        else $error("framing bit not on both pairs");

    even_slot_p2_a: assert property (
        take && q.two && ds1a && q.cnt == 10'h009 |=> q.b1[1] == $past(USR_BIT))
        else $error("second slot not on pair 2");

    byte_p2_a: assert property (
        take && q.two && q.mode == MODE_BYTE && q.cnt == 10'h008 |=> q.b1[0] == $past(USR_BIT))
        else $error("second byte not on pair 2");

    clear_p2_a: assert property (
        take && q.two && q.mode == MODE_CLEAR && q.cnt == {1'b0, ks}
        |=> q.b1[0] == $past(USR_BIT))
        else $error("bit k_s not first on pair 2");

    // ========================================
    // handshake and flag checks
    sob_valid_a: assert property (
        LN_SOB |-> LN_VALID)
        else $error("start of sub-block without valid");

    fill_excl_a: assert property (
        !(USR_READY && LN_VALID))
        else $error("filling and emitting at once");

    cnt_bound_a: assert property (
        q.st == ST_FILL |-> q.cnt < tot)
        else $error("fill counter beyond sub-block period");

    fill_stall_a: assert property (
        q.st == ST_FILL && !USR_VALID && !ctrl_wr |=> q.st == ST_FILL && $stable(q.cnt))
        else $error("fill advanced without user data");

    // a stalled line must see the same bit pair until it takes it
    emit_hold_a: assert property (
        q.st == ST_EMIT && !LN_READY && !ctrl_wr
        |=> q.st == ST_EMIT && $stable({q.b0[0], q.b1[0], q.ecnt}))
        else $error("line bits moved while stalled");

    sbc_still_a: assert property (
        !(q.st == ST_EMIT && LN_READY && q.ecnt == ks - 9'h001) |=> $stable(q.sbc))
        else $error("sub-block count moved without a sub-block");

    aln_flag_a: assert property (
        take && ds1a && q.cnt == 10'h000 && !USR_FRM |=> q.aln_err)
        else $error("missing framing bit not flagged");

    cfg_flag_a: assert property (
        go_wr && !cfg_good |=> q.cfg_err && q.st == ST_IDLE)
        else $error("illegal configuration started a session");

    start_ok_a: assert property (
        go_wr && cfg_good |=> q.st == ST_FILL && q.cnt == 10'h000)
        else $error("legal configuration did not start");

    e1u_range_a: assert property (
        act && q.mode == MODE_E1U |-> q.n >= N_MIN && q.n <= 6'(N_MAX))
        else $error("unstructured slot count out of range");

endmodule

// *** hw/tpm_pkg.sv ***
package tpm_pkg;

    // ========================================
    // register map
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_SBCNT    = 8'h08;

    // ctrl fields
    localparam int          CTRL_START   = 0;
    localparam int          CTRL_MODE_LO = 1;
    localparam int          CTRL_TWO     = 4;
    localparam int          CTRL_N_LO    = 5;
    localparam int          CTRL_I       = 11;

    // status fields
    localparam int          STAT_ACT     = 0;
    localparam int          STAT_CFG_ERR = 1;
    localparam int          STAT_ALN_ERR = 2;

    // ========================================
    // transport modes
    localparam logic [2:0]  MODE_CLEAR   = 3'h0;
    localparam logic [2:0]  MODE_BYTE    = 3'h1;
    localparam logic [2:0]  MODE_DS1U    = 3'h2;
    localparam logic [2:0]  MODE_DS1A    = 3'h3;
    localparam logic [2:0]  MODE_E1U     = 3'h4;
    localparam logic [2:0]  MODE_E1S     = 3'h5;

    // slot count limits
    localparam logic [5:0]  N_MIN        = 6'h03;
    localparam logic [5:0]  N_BYTE_LIM   = 6'h24;
    localparam logic [5:0]  N_DS1        = 6'h18;
    localparam logic [5:0]  N_DS1_TWO    = 6'h0c;
    localparam logic [5:0]  N_E1S        = 6'h20;

    // reset values
    localparam logic [2:0]  RST_MODE     = MODE_CLEAR;
    localparam logic [5:0]  RST_N        = 6'h03;

    // ========================================
    // states, gray along idle -> fill -> emit
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_FILL = 2'h1,
        ST_EMIT = 2'h3
    } tpm_st_e;

endpackage

// *** sim/tpm_line_sink.sv ***
`timescale 1ns/1ps
// ========================================
// line framer stand-in, takes bit pairs and can stall
module tpm_line_sink (
    input  wire logic REF_CLK,
    input  wire logic RSTN,
    input  wire logic slow,
    input  wire logic LN_BIT_P1,
    input  wire logic LN_BIT_P2,
    input  wire logic LN_VALID,
    input  wire logic LN_SOB,
    output logic      LN_READY
);
    logic bits [2][512];
    int   idx;
    int   taken;

    // same clock as the mapper, so frame position never drifts
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            LN_READY <= 1'b0;
            idx <= 0;
            taken <= 0;
        end else begin
            // slow mode stalls every other cycle
            LN_READY <= slow ? !LN_READY : 1'b1;
            if (LN_VALID && LN_READY) begin
                bits[0][LN_SOB ? 0 : idx] <= LN_BIT_P1;
                bits[1][LN_SOB ? 0 : idx] <= LN_BIT_P2;
                idx <= LN_SOB ? 1 : idx + 1;
                taken <= taken + 1;
            end
        end
    end
endmodule

// *** sim/tpm_payload_mapper_bench.sv ***
`timescale 1ns/1ps
module tpm_payload_mapper_bench
    import tpm_pkg::*;
;
    logic        REF_CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0]  PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA;
    logic        PREADY, PSLVERR, USR_READY, LN_BIT_P1, LN_BIT_P2, LN_VALID, LN_SOB;
    logic        USR_BIT = 0, USR_FRM = 0, USR_VALID = 0, LN_TWO_PAIR, LN_READY, slow = 0;
    int          n_errors = 0, samples_checked = 0, cks;
    logic [2:0]  cm;
    logic        ctwo;

    always #12.5 REF_CLK = !REF_CLK;

    tpm_payload_mapper u_dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .USR_BIT(USR_BIT), .USR_FRM(USR_FRM), .USR_VALID(USR_VALID),
        .USR_READY(USR_READY), .LN_BIT_P1(LN_BIT_P1), .LN_BIT_P2(LN_BIT_P2),
        .LN_VALID(LN_VALID), .LN_SOB(LN_SOB), .LN_TWO_PAIR(LN_TWO_PAIR), .LN_READY(LN_READY));
    tpm_line_sink u_sink (.REF_CLK(REF_CLK), .RSTN(RSTN), .slow(slow), .LN_BIT_P1(LN_BIT_P1),
        .LN_BIT_P2(LN_BIT_P2), .LN_VALID(LN_VALID), .LN_SOB(LN_SOB), .LN_READY(LN_READY));

    // ========================================
    // helpers
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do @(posedge REF_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    function automatic logic [31:0] cw(logic [2:0] m, logic two, int n, logic i);
        return 32'h0000_0001 | (32'(m) << CTRL_MODE_LO) | (32'(two) << CTRL_TWO)
             | (32'(n) << CTRL_N_LO) | (32'(i) << CTRL_I);
    endfunction

    // pattern that repeats every 48 bits, six bytes, not every byte
    function automatic logic pat(int k);
        return k[1] ^ k[3] ^ (k % 3 == 0);
    endfunction

    function automatic logic expb(int p, int c);
        if (!ctwo) return p ? 1'b0 : pat(c);
        if (cm == MODE_BYTE) return pat(16 * (c / 8) + 8 * p + c % 8);
        if (cm == MODE_DS1A)
            return c == 0 ? pat(0) : pat(1 + 16 * ((c - 1) / 8) + 8 * p + (c - 1) % 8);
        return pat(p * cks + c);
    endfunction

    // one session: fill one sub-block, compare both pairs, stop
    task automatic run(input logic [2:0] m, input logic two, input int n, input logic i);
        int          tot, k, base, w;
        logic        rdy, e;
        logic [31:0] r0, r;
        cm = m;
        ctwo = two;
        cks = i + 8 * n;
        tot = two ? (m == MODE_DS1A ? 2 * cks - 1 : 2 * cks) : cks;
        base = u_sink.taken;
        apb(0, OFS_SBCNT, 0, r0, e);
        apb(1, OFS_CTRL, cw(m, two, n, i), r, e);
        k = 0;
        USR_BIT <= pat(0);
        USR_FRM <= 1'b1;
        USR_VALID <= 1'b1;
        while (k < tot) begin
            @(negedge REF_CLK);
            rdy = USR_READY;
            @(posedge REF_CLK);
            if (rdy) begin
                k++;
                USR_BIT <= pat(k);
                USR_FRM <= 1'b0;
            end
        end
        USR_VALID <= 1'b0;
        w = 0;
        while (u_sink.taken < base + cks && w < 2000) begin
            @(posedge REF_CLK);
            w++;
        end
        check(u_sink.taken, base + cks);
        for (int c = 0; c < cks; c++)
            for (int p = 0; p < 2; p++)
                check(u_sink.bits[p][c], expb(p, c));
        check(LN_TWO_PAIR, two);
        apb(0, OFS_SBCNT, 0, r, e);
        check(r[15:0], r0[15:0] + 16'h0001);
        apb(0, OFS_STATUS, 0, r, e);
        check(r & 32'h0000_0007, 32'h0000_0001);
        apb(1, OFS_CTRL, 0, r, e);
    endtask

    // ========================================
    // scenarios
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        apb(0, OFS_CTRL, 0, r, e);
        check(r, 32'(RST_N) << CTRL_N_LO);
        apb(0, OFS_STATUS, 0, r, e);
        check(r, 0);
        apb(0, 8'h0C, 0, r, e);
        check(e, 1'b1);
    endtask

    task automatic t_clear();
        slow <= 1'b1;
        run(MODE_CLEAR, 1'b0, 3, 1'b1);
        run(MODE_CLEAR, 1'b1, 3, 1'b0);
        slow <= 1'b0;
        run(MODE_E1U, 1'b0, 4, 1'b0);
    endtask

    task automatic t_byte();
        run(MODE_BYTE, 1'b0, 4, 1'b0);
        run(MODE_BYTE, 1'b1, 4, 1'b0);
    endtask

    task automatic t_frame();
        run(MODE_DS1U, 1'b0, 24, 1'b1);
        run(MODE_E1S, 1'b0, 32, 1'b0);
        run(MODE_DS1A, 1'b0, 24, 1'b1);
        slow <= 1'b1;
        run(MODE_DS1A, 1'b1, 4, 1'b1);
        slow <= 1'b0;
    endtask

    // framing bit missing on the first bit must raise the align flag
    task automatic t_align();
        logic [31:0] r;
        logic        e;
        apb(1, OFS_CTRL, cw(MODE_DS1A, 1'b0, 3, 1'b1), r, e);
        USR_FRM <= 1'b0;
        USR_VALID <= 1'b1;
        apb(0, OFS_STATUS, 0, r, e);
        USR_VALID <= 1'b0;
        check(r & 32'h0000_0007, 32'h0000_0005);
        apb(1, OFS_STATUS, 32'h0000_0004, r, e);
        apb(1, OFS_CTRL, 0, r, e);
        apb(0, OFS_STATUS, 0, r, e);
        check(r, 0);
    endtask

    task automatic refuse(input logic [2:0] m, input int n, input logic i);
        logic [31:0] r;
        logic        e;
        apb(1, OFS_CTRL, cw(m, 1'b1, n, i), r, e);
        apb(0, OFS_STATUS, 0, r, e);
        check(r & 32'h0000_0003, 32'h0000_0002);
        apb(1, OFS_STATUS, 32'h0000_0002, r, e);
    endtask

    task automatic t_refuse();
        refuse(MODE_BYTE, 3, 1'b0);
        refuse(MODE_DS1U, 24, 1'b1);
        refuse(MODE_E1S, 32, 1'b0);
    endtask

    initial begin
        repeat (20) @(posedge REF_CLK);
        RSTN <= 1'b1;
        t_regs();
        t_clear();
        t_byte();
        t_frame();
        t_align();
        t_refuse();
        close_out();
    end

    // whole run needs well under 20000 cycles
    initial begin
        #(25 * 60000);
        n_errors++;
        close_out();
    end
endmodule
